// ===== host_model.sv
// behavioural bus host: clock, data and alert response
`timescale 1ns/10ps
module host_model
(
    output logic scl,
    output logic sda_drv,
    input wire logic sda_wire
);
    import supply_cmd_pkg::*;
    // ****************
    // wire primitives
    // ****************
    // released lines rise through the pull-ups
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // also a repeated start: sda lifts only after the slave lets go
    task automatic start_cond();
    begin
        #50 sda_drv = 1'b1;
        #50 scl = 1'b1;
        #50 sda_drv = 1'b0;
        #50 scl = 1'b0;
    end
    endtask
    task automatic stop_cond();
    begin
        #50 sda_drv = 1'b0;
        #50 scl = 1'b1;
        #50 sda_drv = 1'b1;
        #100;
    end
    endtask
    // long low phase leaves room for the slave's synchroniser
    task automatic put_bit(input logic b, output logic seen);
    begin
        #25 sda_drv = b;
        #125 seen = sda_wire;
        scl = 1'b1;
        #50 scl = 1'b0;
    end
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
    begin
        for (int i = 7; i >= 0; i--)
            put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    end
    endtask
    // last high means the host does not acknowledge
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
    begin
        for (int i = 7; i >= 0; i--)
            put_bit(1'b1, b[i]);
        put_bit(last, s);
    end
    endtask
    // ****************
    // alert response
    // ****************
    // host polls the response address and reads one address byte
    task automatic alert_response(output logic ack, output logic [7:0] b);
    begin
        start_cond();
        put_byte({ARA_ADDR, 1'b1}, ack);
        get_byte(1'b0, b);
        stop_cond();
    end
    endtask
endmodule

// ===== supply_cmd_pkg.sv
// constants and types for the supply command logic
package supply_cmd_pkg;
    // ***********************
    // bus addresses and codes
    // ***********************
    localparam logic [6:0] ARA_ADDR = 7'h0c;
    localparam logic [6:0] OWN_ADDR = 7'h40;
    localparam logic [7:0] CMD_SEL = 8'h00;
    localparam logic [7:0] CMD_RUN = 8'h01;
    localparam logic [7:0] CMD_CFG = 8'h02;
    localparam logic [7:0] CMD_CLR = 8'h03;
    localparam logic [7:0] CMD_STAT = 8'h78;
    localparam logic [7:0] CMD_VFLT = 8'h80;
    localparam logic [7:0] SEL_ALL = 8'hff;
    localparam logic [7:0] SEL_MAX = 8'h03;
    // ***********************
    // reset values and codes
    // ***********************
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] RUN_RESET = 8'h00;
    localparam logic [4:0] CFG_RESET = 5'h1a;
    localparam logic [7:0] RUN_OFF_NOW = 8'h00;
    localparam logic [7:0] RUN_OFF_SOFT = 8'h40;
    localparam logic [7:0] RUN_ON = 8'h80;
    localparam logic [7:0] RUN_LO_IGN = 8'h94;
    localparam logic [7:0] RUN_LO_ACT = 8'h98;
    localparam logic [7:0] RUN_HI_IGN = 8'ha4;
    localparam logic [7:0] RUN_HI_ACT = 8'ha8;
    // ***********************
    // field positions
    // ***********************
    localparam int CFG_GATE = 4;
    localparam int CFG_BUS = 3;
    localparam int CFG_PIN = 2;
    localparam int CFG_POL = 1;
    localparam int CFG_FAST = 0;
    localparam int RUN_ONB = 7;
    localparam int RUN_HIB = 5;
    localparam int RUN_LOB = 4;
    localparam int RUN_ACTB = 3;
    localparam int VF_REF = 4;
    localparam int VF_CML = 5;
    localparam int NCH = 4;
    localparam logic [3:0] BIT_LAST = 4'h8;
    typedef enum logic [2:0] {
        B_IDLE = 3'b000, B_ADDR = 3'b001, B_CMD = 3'b010,
        B_WDATA = 3'b011, B_ACK = 3'b100, B_TX = 3'b101,
        B_RACK = 3'b110, B_SKIP = 3'b111
    } bus_state_t;
    typedef struct packed {
        logic enable;
        logic quick_off;
        logic margin_high;
        logic margin_low;
    } chan_out_t;
    typedef struct packed {
        logic fault;
        logic ov;
        logic uv;
    } chan_mon_t;
endpackage

// ===== supply_onoff_fault_cmd_logic.sv
// serial command logic: paging, run state, on/off config, faults
`timescale 1ns/10ps
module supply_onoff_fault_cmd_logic
(
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic alert_out,
    output logic alert_oe_n,
    input wire logic remote_on_input,
    input wire logic ref_fail,
    input supply_cmd_pkg::chan_mon_t [3:0] mon,
    output supply_cmd_pkg::chan_out_t [3:0] chan_out,
    output logic comm_fault_flag
);
    import supply_cmd_pkg::*;

    // ***********************
    // pin synchronisers
    // ***********************
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic scl_d;
    logic sda_d;
    // scl, sda, control pin, reference flag: all asynchronous
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // bus pins idle high; control and reference idle low
            sync_a <= 4'h3;
            sync_b <= 4'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            sync_a <= {ref_fail, remote_on_input, sda_in, scl_in};
            sync_b <= sync_a;
            scl_d <= sync_b[0];
            sda_d <= sync_b[1];
        end
    end

    logic scl_s, sda_s, ctrl_s, ref_s;
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_s = sync_b[0];
    assign sda_s = sync_b[1];
    assign ctrl_s = sync_b[2];
    assign ref_s = sync_b[3];
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_c = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

    // ***********************
    // bus engine
    // ***********************
    bus_state_t state, ack_next;
    logic [3:0] bcnt;
    logic [7:0] sr, tx, cmd, wdata, sel;
    logic [1:0] nbytes;
    logic have_cmd, ara, alert_q;
    logic wr_stb, clr_stb, cml_evt, ara_done;
    logic [7:0] rdata;
    logic [7:0] run_state [NCH];
    logic [4:0] cfg [NCH];
    logic [5:0] vfault;
    logic supported, need, rd_ok, sel_all;
    assign sel_all = (sel == SEL_ALL);
    assign supported = (sr == CMD_SEL) | (sr == CMD_RUN) | (sr == CMD_CFG)
        | (sr == CMD_CLR) | (sr == CMD_STAT) | (sr == CMD_VFLT);
    assign need = (cmd == CMD_SEL) | (cmd == CMD_RUN) | (cmd == CMD_CFG);
    assign rd_ok = have_cmd & (cmd != CMD_CLR);

    // read data: run and config for the selected channel; select and fault bytes are not per channel
    always_comb
    begin
        case (cmd)
            CMD_SEL: rdata = sel;
            CMD_RUN: rdata = run_state[sel[1:0]];
            CMD_CFG: rdata = {3'h0, cfg[sel[1:0]]};
            CMD_STAT: rdata = {5'h00, vfault[VF_REF], vfault[VF_CML],
                |vfault[3:0]};
            default: rdata = {2'h0, vfault};
        endcase
    end

    // byte level slave plus alert response; commits land on stop
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= B_IDLE;
            ack_next <= B_IDLE;
            bcnt <= 4'h0;
            sr <= 8'h00;
            tx <= 8'h00;
            cmd <= 8'h00;
            wdata <= 8'h00;
            nbytes <= 2'h0;
            have_cmd <= 1'b0;
            ara <= 1'b0;
            sda_oe_n <= 1'b1;
            wr_stb <= 1'b0;
            clr_stb <= 1'b0;
            cml_evt <= 1'b0;
            ara_done <= 1'b0;
        end
        else
        begin
            wr_stb <= 1'b0;
            clr_stb <= 1'b0;
            cml_evt <= 1'b0;
            ara_done <= 1'b0;
            if (stop_c)
            begin
                if (state == B_WDATA)
                begin
                    if (cmd == CMD_CLR && nbytes == 2'h0)
                        clr_stb <= 1'b1;
                    else if (need && nbytes == 2'h1)
                        wr_stb <= 1'b1;
                    else if (need && nbytes == 2'h0)
                        cml_evt <= 1'b1;
                end
                state <= B_IDLE;
                sda_oe_n <= 1'b1;
                have_cmd <= 1'b0;
            end
            else if (start_c)
            begin
                // repeated start after a bare code keeps it for a read
                have_cmd <= (state == B_WDATA) && (nbytes == 2'h0);
                state <= B_ADDR;
                bcnt <= 4'h0;
                ara <= 1'b0;
                sda_oe_n <= 1'b1;
            end
            else
            begin
                case (state)
                    B_ADDR, B_CMD, B_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            sr <= {sr[6:0], sda_s};
                            bcnt <= bcnt + 4'h1;
                        end
                        else if (scl_fall && bcnt == BIT_LAST)
                        begin
                            bcnt <= 4'h0;
                            state <= B_ACK;
                            sda_oe_n <= 1'b0;
                            if (state == B_ADDR)
                            begin
                                if (sr[7:1] == OWN_ADDR && !sr[0])
                                    ack_next <= B_CMD;
                                else if (sr[7:1] == OWN_ADDR && rd_ok
                                    && !(sel_all && (cmd == CMD_RUN
                                    || cmd == CMD_CFG)))
                                begin
                                    tx <= rdata;
                                    ack_next <= B_TX;
                                end
                                else if (sr == {ARA_ADDR, 1'b1} && alert_q)
                                begin
                                    tx <= {OWN_ADDR, 1'b0};
                                    ara <= 1'b1;
                                    ack_next <= B_TX;
                                end
                                else
                                begin
                                    // write-only read dropped quietly
                                    state <= B_SKIP;
                                    sda_oe_n <= 1'b1;
                                    cml_evt <= sr[7:1] == OWN_ADDR
                                        && sr[0] && rd_ok;
                                end
                            end
                            else if (state == B_CMD)
                            begin
                                cmd <= sr;
                                nbytes <= 2'h0;
                                ack_next <= B_WDATA;
                                if (!supported)
                                begin
                                    state <= B_SKIP;
                                    sda_oe_n <= 1'b1;
                                end
                            end
                            else
                            begin
                                wdata <= sr;
                                ack_next <= B_WDATA;
                                if (nbytes != 2'h3)
                                    nbytes <= nbytes + 2'h1;
                                if (nbytes >= {1'b0, need})
                                    cml_evt <= 1'b1;
                            end
                        end
                    end
                    B_ACK:
                    begin
                        if (scl_fall)
                        begin
                            state <= ack_next;
                            sda_oe_n <= (ack_next == B_TX) ? tx[7] : 1'b1;
                        end
                    end
                    B_TX:
                    begin
                        if (scl_rise)
                            bcnt <= bcnt + 4'h1;
                        else if (scl_fall && bcnt == BIT_LAST)
                        begin
                            state <= B_RACK;
                            sda_oe_n <= 1'b1;
                        end
                        else if (scl_fall)
                        begin
                            tx <= {tx[6:0], 1'b0};
                            sda_oe_n <= tx[6];
                        end
                    end
                    B_RACK:
                    begin
                        if (scl_rise)
                        begin
                            ara_done <= ara;
                            state <= B_SKIP;
                        end
                    end
                    default:
                    begin
                        bcnt <= 4'h0;
                    end
                endcase
            end
        end
    end

    // ***********************
    // registers and channels
    // ***********************
    logic run_ok, sel_ok, wr_bad;
    logic [NCH-1:0] want, on_rise, qual;
    assign run_ok = (wdata == RUN_OFF_NOW) | (wdata == RUN_OFF_SOFT)
        | (wdata == RUN_ON) | (wdata == RUN_LO_IGN) | (wdata == RUN_LO_ACT)
        | (wdata == RUN_HI_IGN) | (wdata == RUN_HI_ACT);
    assign sel_ok = (wdata <= SEL_MAX) | (wdata == SEL_ALL);
    assign wr_bad = wr_stb & (((cmd == CMD_RUN) & ~run_ok)
        | ((cmd == CMD_SEL) & ~sel_ok));

    // channel select; out of range values are refused
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sel <= SEL_RESET;
        else if (wr_stb && cmd == CMD_SEL && sel_ok)
            sel <= wdata;
    end

    genvar i;
    generate
        for (i = 0; i < NCH; i++)
        begin : g_ch
            logic hit, ctrl_on, bus_on;
            assign hit = sel_all | (sel[1:0] == 2'(i));
            assign ctrl_on = ctrl_s ~^ cfg[i][CFG_POL];
            assign bus_on = run_state[i][RUN_ONB];
            // state held until a new order arrives
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    run_state[i] <= RUN_RESET;
                    cfg[i] <= CFG_RESET;
                end
                else if (wr_stb && hit)
                begin
                    if (cmd == CMD_RUN && run_ok)
                        run_state[i] <= wdata;
                    if (cmd == CMD_CFG)
                        cfg[i] <= wdata[4:0];
                end
            end
            assign want[i] = ~cfg[i][CFG_GATE]
                | ((~cfg[i][CFG_BUS] | bus_on)
                & (~cfg[i][CFG_PIN] | ctrl_on));
            assign on_rise[i] = want[i] & ~chan_out[i].enable;
            // act-on-fault margins treat ov (margin high) or uv (margin low) as faults
            assign qual[i] = mon[i].fault | (run_state[i][RUN_ACTB]
                & ((run_state[i][RUN_HIB] & mon[i].ov)
                | (run_state[i][RUN_LOB] & mon[i].uv)));
            // fast drop: 00h from the bus or the pin with fast set
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    chan_out[i] <= '0;
                else
                begin
                    chan_out[i].enable <= want[i];
                    chan_out[i].quick_off <= ~want[i]
                        & ((cfg[i][CFG_BUS] & (run_state[i] == RUN_OFF_NOW))
                        | (cfg[i][CFG_PIN] & ~ctrl_on
                        & cfg[i][CFG_FAST]));
                    chan_out[i].margin_high <= want[i] & bus_on
                        & run_state[i][RUN_HIB];
                    chan_out[i].margin_low <= want[i] & bus_on
                        & run_state[i][RUN_LOB];
                end
            end
            power_gate_a: assert property (@(posedge clk) disable iff (rst)
                !cfg[i][CFG_GATE] |=> chan_out[i].enable)
                else $error("enable not forced by power gate");
        end
    endgenerate

    // ***********************
    // fault status and alert
    // ***********************
    logic [5:0] set_vec, clr_mask;
    logic clear_all;
    assign set_vec = {cml_evt | wr_bad, ref_s, qual};
    assign clear_all = clr_stb | (|on_rise);
    // reference bit survives every clear but reset
    assign clr_mask = clear_all ? 6'h10 : 6'h3f;
    // set beats clear, so a live fault comes right back
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            vfault <= 6'h00;
        else
            vfault <= (vfault & clr_mask) | set_vec;
    end

    // alert latches on new bits, a fault still live across a clear
    // counts as new so the host hears of it again
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            alert_q <= 1'b0;
        else if (|(set_vec & ~(vfault & clr_mask)))
            alert_q <= 1'b1;
        else if (clear_all || ara_done)
            alert_q <= 1'b0;
    end

    // open-drain pins: output level fixed low, enable low drives
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            alert_oe_n <= 1'b1;
            alert_out <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            alert_oe_n <= ~(alert_q | vfault[VF_REF]);
            alert_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end
    assign comm_fault_flag = vfault[VF_CML];

    alert_set_a: assert property (@(posedge clk) disable iff (rst)
        |(set_vec & ~vfault) |-> ##2 !alert_oe_n)
        else $error("alert not driven after new fault");
    clear_rel_a: assert property (@(posedge clk) disable iff (rst)
        clr_stb && set_vec == 6'h00 |=> !alert_q && vfault[3:0] == 4'h0)
        else $error("clear did not release");
    ref_hold_a: assert property (@(posedge clk) disable iff (rst)
        vfault[VF_REF] |=> vfault[VF_REF] ##1 !alert_oe_n)
        else $error("reference fault lost");
    nack_cmd_a: assert property (@(posedge clk) disable iff (rst)
        state == B_CMD && scl_fall && bcnt == BIT_LAST && !supported
        && !stop_c && !start_c |=> sda_oe_n && state == B_SKIP)
        else $error("unsupported code acknowledged");
    too_few_a: assert property (@(posedge clk) disable iff (rst)
        stop_c && state == B_WDATA && need && nbytes == 2'h0
        |-> ##2 comm_fault_flag)
        else $error("short write not flagged");
    too_many_a: assert property (@(posedge clk) disable iff (rst)
        state == B_WDATA && scl_fall && bcnt == BIT_LAST && !stop_c
        && !start_c && nbytes >= {1'b0, need} |=> ##1 comm_fault_flag)
        else $error("long write not flagged");
    wo_abort_a: assert property (@(posedge clk) disable iff (rst)
        state == B_ADDR && scl_fall && bcnt == BIT_LAST && !stop_c
        && !start_c && sr == {OWN_ADDR, 1'b1} && have_cmd
        && cmd == CMD_CLR |=> !cml_evt && sda_oe_n)
        else $error("write-only read not aborted");
    bad_run_a: assert property (@(posedge clk) disable iff (rst)
        wr_stb && cmd == CMD_RUN && !run_ok
        |=> comm_fault_flag && $stable(run_state[0]))
        else $error("invalid run byte accepted");
endmodule

// ===== tb.sv
// self-checking bench for the supply command logic
`timescale 1ns/10ps
module tb;
    import supply_cmd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic remote = 1'b0;
    logic ref_fail = 1'b0;
    chan_mon_t [3:0] mon = '0;
    wire scl;
    logic sda_drv;
    wire sda_wire;
    logic sda_out, sda_oe_n, alert_out, alert_oe_n, comm_fault_flag;
    chan_out_t [3:0] chan_out;
    logic [3:0] en;
    logic ack;
    logic [7:0] d;
    int num_errors = 0;
    int samples_checked = 0;
    logic [7:0] codes [5] = '{RUN_ON, RUN_LO_IGN, RUN_LO_ACT,
        RUN_HI_IGN, RUN_HI_ACT};
    // {config, 0, remote level, enable, quick off}
    logic [11:0] cfg_tab [7] = '{12'h166, 12'h160, 12'h176, 12'h171,
        12'h142, 12'h002, 12'h1e4};
    // ****************
    // wiring
    // ****************
    // open drain: either party pulls low, pull-up otherwise
    assign sda_wire = sda_drv & (sda_oe_n | sda_out);
    always #12.5 clk = ~clk;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            en[i] = chan_out[i].enable;
    end
    supply_onoff_fault_cmd_logic u_supply_onoff_fault_cmd_logic
    (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n), .remote_on_input(remote),
        .ref_fail(ref_fail), .mon(mon), .chan_out(chan_out),
        .comm_fault_flag(comm_fault_flag)
    );
    host_model u_host_model
    (
        .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire)
    );
    // ****************
    // bench tasks
    // ****************
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
    begin
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    end
    endtask
    task automatic chkb(input string n, input logic e, input logic g);
    begin
        chk(n, {7'h0, e}, {7'h0, g});
    end
    endtask
    // synchronisers need a few cycles after any pin change
    task automatic settle();
    begin
        repeat (8) @(posedge clk);
        #1;
    end
    endtask
    // n data bytes written, or one byte read back when rdx is set
    task automatic xfer(input logic [7:0] c, input logic [7:0] v,
        input int n, input logic rdx);
        logic a;
    begin
        @(posedge clk);
        #1;
        u_host_model.start_cond();
        u_host_model.put_byte({OWN_ADDR, 1'b0}, a);
        u_host_model.put_byte(c, ack);
        for (int i = 0; i < n; i++)
            u_host_model.put_byte(v, a);
        if (rdx)
        begin
            u_host_model.start_cond();
            u_host_model.put_byte({OWN_ADDR, 1'b1}, a);
            u_host_model.get_byte(1'b1, d);
        end
        u_host_model.stop_cond();
        settle();
    end
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] v);
    begin
        xfer(c, v, 1, 1'b0);
    end
    endtask
    task automatic rd(input logic [7:0] c);
    begin
        xfer(c, 8'h00, 0, 1'b1);
    end
    endtask
    task automatic end_of_test();
    begin
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    // ****************
    // tests
    // ****************
    // a hang is counted as a mismatch
    initial
    begin
        #2000000;
        num_errors++;
        end_of_test();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        settle();
        rd(CMD_RUN);
        chk("run reset", RUN_RESET, d);
        chk("enables", 8'h00, {4'h0, en});
        for (int k = 0; k < 5; k++)
        begin
            wr(CMD_RUN, codes[k]);
            chk("ch0", {5'h01, 1'b0, codes[k][5:4]},
                {4'h0, chan_out[0]});
            rd(CMD_RUN);
            chk("run back", codes[k], d);
        end
        // margined high with act on fault: uv ignored, ov latched
        mon[0].uv = 1'b1;
        settle();
        chkb("uv ignored", 1'b1, alert_oe_n);
        mon[0] = 3'b010;
        rd(CMD_VFLT);
        chk("ov acted", 8'h01, d);
        mon[0] = '0;
        xfer(CMD_CLR, 8'h00, 0, 1'b0);
        wr(CMD_RUN, 8'h55);
        chkb("cml bad run", 1'b1, comm_fault_flag);
        chkb("alert bad run", 1'b0, alert_oe_n);
        rd(CMD_RUN);
        chk("run kept", RUN_HI_ACT, d);
        u_host_model.alert_response(ack, d);
        chkb("ara ack", 1'b1, ack);
        chk("ara addr", {OWN_ADDR, 1'b0}, d);
        settle();
        chkb("alert off", 1'b1, alert_oe_n);
        xfer(CMD_CLR, 8'h00, 0, 1'b0);
        chkb("cml clr", 1'b0, comm_fault_flag);
        chkb("en kept", 1'b1, en[0]);
        wr(CMD_RUN, RUN_OFF_SOFT);
        chk("soft off", 8'h00, {4'h0, chan_out[0]});
        wr(CMD_RUN, RUN_ON);
        wr(CMD_RUN, RUN_OFF_NOW);
        chk("fast off", 8'h04, {4'h0, chan_out[0]});
        wr(8'h10, 8'h00);
        chkb("unsupported", 1'b0, ack);
        rd(CMD_CLR);
        chkb("rd write-only", 1'b0, comm_fault_flag);
        chkb("rd wo alert", 1'b1, alert_oe_n);
        xfer(CMD_RUN, 8'h00, 0, 1'b0);
        chkb("too few", 1'b1, comm_fault_flag);
        xfer(CMD_CLR, 8'h00, 0, 1'b0);
        xfer(CMD_RUN, RUN_ON, 2, 1'b0);
        chkb("too many", 1'b1, comm_fault_flag);
        xfer(CMD_CLR, 8'h00, 0, 1'b0);
        wr(CMD_SEL, SEL_ALL);
        wr(CMD_RUN, RUN_ON);
        chk("all on", 8'h0f, {4'h0, en});
        rd(CMD_RUN);
        chkb("page all", 1'b1, comm_fault_flag);
        wr(CMD_SEL, 8'h01);
        wr(CMD_RUN, RUN_OFF_NOW);
        chk("ch1 off", 8'h0d, {4'h0, en});
        wr(CMD_RUN, RUN_ON);
        chkb("off-on clr", 1'b0, comm_fault_flag);
        // a monitor fault that persists comes back after clearing
        mon[2].fault = 1'b1;
        settle();
        chkb("fault alert", 1'b0, alert_oe_n);
        chkb("alert level", 1'b0, alert_out);
        rd(CMD_VFLT);
        chk("vendor", 8'h04, d);
        rd(CMD_STAT);
        chk("summary", 8'h01, d);
        xfer(CMD_CLR, 8'h00, 0, 1'b0);
        rd(CMD_VFLT);
        chk("refault", 8'h04, d);
        chkb("realert", 1'b0, alert_oe_n);
        mon[2].fault = 1'b0;
        xfer(CMD_CLR, 8'h00, 0, 1'b0);
        rd(CMD_VFLT);
        chk("cleared", 8'h00, d);
        // reference loss survives response and clear, not reset
        ref_fail = 1'b1;
        settle();
        ref_fail = 1'b0;
        u_host_model.alert_response(ack, d);
        xfer(CMD_CLR, 8'h00, 0, 1'b0);
        chkb("ref alert", 1'b0, alert_oe_n);
        rst = 1'b1;
        settle();
        rst = 1'b0;
        settle();
        chkb("ref reset", 1'b1, alert_oe_n);
        for (int k = 0; k < 7; k++)
        begin
            wr(CMD_CFG, cfg_tab[k][11:4]);
            remote = cfg_tab[k][2];
            settle();
            chkb("cfg en", cfg_tab[k][1], en[0]);
            if (k < 6)
                chkb("cfg qo", cfg_tab[k][0],
                    chan_out[0].quick_off);
        end
        end_of_test();
    end
endmodule
